// [design/config_word_latch.sv]
`timescale 1ns/1ps
`include "device_config_params.svh"

// catches one nonvolatile word once after reset release
module config_word_latch #(
  parameter int WIDTH = 32
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] nv_word,
  output logic      [WIDTH-1:0] word,
  output logic                  held
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;    // first sync stage, read only by s2
    logic [WIDTH-1:0] s2;    // second sync stage
    logic [1:0]       fill;  // stages filled since release
    logic [WIDTH-1:0] word;  // captured value
    logic             held;  // capture done
  } latch_state_t;

  latch_state_t q;
  latch_state_t d;

  // capture once; later changes of the array are never seen
  always_comb begin
    d      = q;
    d.s1   = nv_word;
    d.s2   = q.s1;
    d.fill = {q.fill[0], 1'b1};
    if (q.fill == `LATCH_FILL && !q.held) begin
      d.word = q.s2;
      d.held = 1'b1;
    end
  end

  // constants only under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.s1   <= `CFG_ERASED;
      q.s2   <= `CFG_ERASED;
      q.fill <= 2'h0;
      q.word <= `CFG_ERASED;
      q.held <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign word = q.word;
  assign held = q.held;

endmodule // config_word_latch

// [design/device_config_words.sv]
`timescale 1ns/1ps
`include "device_config_params.svh"

// What this block does
// R1 - code protect zero refuses programmer flash access
// R2 - boot write protect zero blocks boot writes
// R3 - four config words, word three lowest
// R4 - read-only identification word with three fields
// R5 - programmer keeps reserved protection bits at one; the programmer model clears bits 31 to 29
// R6 - page field complement counts protected pages
// R7 - debugger on at 10, off under protection
// R8 - channel select bit picks debug pin pair
// R9 - words latched at reset, software read-only
module device_config_words #(
  parameter logic [3:0]  REVISION = 4'h1,    // arbitrary value
  parameter logic [7:0]  PART     = 8'h5a,   // arbitrary value
  parameter logic [11:0] MAKER    = 12'h0a5  // arbitrary value, bit 0 forced to one
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [31:0] nv_word0,
  input  wire logic [31:0] nv_word1,
  input  wire logic [31:0] nv_word2,
  input  wire logic [31:0] nv_word3,
  input  wire logic        prog_access_req,
  output logic             prog_access_grant,
  output logic             prog_access_deny,
  input  wire logic        boot_write_req,
  output logic             boot_write_grant,
  output logic             boot_write_deny,
  input  wire logic        page_write_req,
  input  wire logic [7:0]  page_write_index,
  output logic             page_write_grant,
  output logic             page_write_deny,
  output logic             debug_enable,
  output logic             debug_channel_select,
  output logic             config_valid
);

  // latched words, index = configuration word number
  logic [31:0] cfg_word [4];
  logic [3:0]  cfg_held;
  logic [31:0] nv_in    [4];

  device_config_pkg::cfg_state_t q;
  device_config_pkg::cfg_state_t d;

  // decoded protection fields of word zero
  logic        code_protect;        // zero means protection on
  logic        boot_write_protect;  // zero means boot locked
  logic [7:0]  page_write_protect;  // complement of page count
  logic [7:0]  protected_pages;     // pages locked from the bottom
  logic [1:0]  debug_field;         // raw debugger enable code
  logic [31:0] ident_word;          // fixed identification value
  logic [31:0] status_word;         // live view of derived state
  logic        rd_access;           // read address phase accepted
  logic [31:0] rd_mux;              // word selected by haddr

  assign nv_in[0] = nv_word0;
  assign nv_in[1] = nv_word1;
  assign nv_in[2] = nv_word2;
  assign nv_in[3] = nv_word3;

  // one capture stage per configuration word
  // R9 latch at reset
  for (genvar i = 0; i < 4; i++) begin : g_latch
    config_word_latch #(
      .WIDTH (32)
    ) u_latch (
      .hclk    (hclk),
      .hresetn (hresetn),
      .nv_word (nv_in[i]),
      .word    (cfg_word[i]),
      .held    (cfg_held[i])
    );
  end

  // all words captured together, so any one flag would do
  assign config_valid = &cfg_held;

  // field extraction from the protection word
  assign code_protect       = cfg_word[0][`CODE_PROTECT_BIT];
  assign boot_write_protect = cfg_word[0][`BOOT_WP_BIT];
  assign page_write_protect = cfg_word[0][`PAGE_WP_MSB:`PAGE_WP_LSB];
  assign debug_field        = cfg_word[0][`DBG_EN_MSB:`DBG_EN_LSB];
  // R6 complement count
  assign protected_pages    = ~page_write_protect;

  // identification word; makers bit 0 always reads one
  // R4 id layout
  always_comb begin
    ident_word                         = 32'h00000000;
    ident_word[`REV_MSB:`REV_LSB]      = REVISION;
    ident_word[`PART_MSB:`PART_LSB]    = PART;
    ident_word[`MAKER_MSB:`MAKER_LSB]  = MAKER | 12'h001;
  end

  // status word gathers what the block decided
  always_comb begin
    status_word                                  = 32'h00000000;
    status_word[`STAT_VALID_BIT]                 = config_valid;
    status_word[`STAT_CP_BIT]                    = ~code_protect;
    status_word[`STAT_DBG_BIT]                   = q.dbg_en;
    status_word[`STAT_BOOT_BIT]                  = ~boot_write_protect;
    status_word[`STAT_PAGES_MSB:`STAT_PAGES_LSB] = protected_pages;
  end

  // only single word reads matter; writes and sizes are ignored
  assign rd_access = hsel && hready && htrans[1] && !hwrite;

  // address decode of the read-only map
  // R3 word map
  always_comb begin
    unique case (haddr)
      `CFG_WORD3_ADDR:   rd_mux = cfg_word[3];
      `CFG_WORD2_ADDR:   rd_mux = cfg_word[2];
      `CFG_WORD1_ADDR:   rd_mux = cfg_word[1];
      `CFG_WORD0_ADDR:   rd_mux = cfg_word[0];
      `IDENT_WORD_ADDR:  rd_mux = ident_word;
      `STATUS_WORD_ADDR: rd_mux = status_word;
      // unmapped addresses read as zero
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // next state: bus read data and the protection decisions
  always_comb begin
    d            = q;
    d.prog_grant = 1'b0;
    d.prog_deny  = 1'b0;
    d.boot_grant = 1'b0;
    d.boot_deny  = 1'b0;
    d.page_grant = 1'b0;
    d.page_deny  = 1'b0;
    // read data is caught at the address phase, shown in the data phase
    if (rd_access) begin
      d.rdata = rd_mux;
    end
    // R1 programmer gate
    if (prog_access_req) begin
      // refuse until the words are known; safe default
      if (config_valid && code_protect) begin
        d.prog_grant = 1'b1;
      end else begin
        d.prog_deny = 1'b1;
      end
    end
    // R2 boot write gate
    if (boot_write_req) begin
      if (config_valid && boot_write_protect) begin
        d.boot_grant = 1'b1;
      end else begin
        d.boot_deny = 1'b1;
      end
    end
    // R6 page write gate
    if (page_write_req) begin
      if (config_valid && page_write_index >= protected_pages) begin
        d.page_grant = 1'b1;
      end else begin
        d.page_deny = 1'b1;
      end
    end
    // R7 debugger enable, forced off under protection
    d.dbg_en  = config_valid && code_protect && (debug_field == `DBG_EN_ON);
    // R8 pin pair select
    d.dbg_sel = config_valid && cfg_word[0][`DBG_SEL_BIT];
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.rdata      <= `RDATA_RESET;
      q.prog_grant <= 1'b0;
      q.prog_deny  <= 1'b0;
      q.boot_grant <= 1'b0;
      q.boot_deny  <= 1'b0;
      q.page_grant <= 1'b0;
      q.page_deny  <= 1'b0;
      q.dbg_en     <= 1'b0;
      q.dbg_sel    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // zero wait states, always okay
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign hrdata               = q.rdata;
  assign prog_access_grant    = q.prog_grant;
  assign prog_access_deny     = q.prog_deny;
  assign boot_write_grant     = q.boot_grant;
  assign boot_write_deny      = q.boot_deny;
  assign page_write_grant     = q.page_grant;
  assign page_write_deny      = q.page_deny;
  assign debug_enable         = q.dbg_en;
  assign debug_channel_select = q.dbg_sel;

  // checks on the decisions and the read path
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read(logic [31:0] a);
    rd_access && haddr == a;
  endsequence

  sequence s_protected_boot;
    boot_write_req && config_valid && !boot_write_protect;
  endsequence

  property p_cp_refuses;  // R1
    prog_access_req && !code_protect |=> prog_access_deny && !prog_access_grant;
  endproperty
  a_cp_refuses: assert property (p_cp_refuses) else $error("programmer passed protection");

  property p_boot_locked;  // R2
    s_protected_boot |=> boot_write_deny ##0 !boot_write_grant;
  endproperty
  a_boot_locked: assert property (p_boot_locked) else $error("boot write not refused");

  property p_word3_read;  // R3
    s_read(`CFG_WORD3_ADDR) |=> hrdata == $past(cfg_word[3]);
  endproperty
  a_word3_read: assert property (p_word3_read) else $error("word three misread");

  property p_ident_read;  // R4
    s_read(`IDENT_WORD_ADDR) |=> hrdata[`MAKER_LSB] && hrdata[`REV_MSB:`REV_LSB] == REVISION;
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("identification misread");

  property p_page_locked;  // R6
    page_write_req && page_write_index < protected_pages |=> page_write_deny;
  endproperty
  a_page_locked: assert property (p_page_locked) else $error("protected page written");

  property p_debug_forced_off;  // R7
    config_valid && !code_protect |=> !debug_enable;
  endproperty
  a_debug_forced_off: assert property (p_debug_forced_off) else $error("debugger on under protection");

  property p_channel_read;  // R8
    config_valid ##1 s_read(`CFG_WORD0_ADDR) |=> hrdata[`DBG_SEL_BIT] == debug_channel_select;
  endproperty
  a_channel_read: assert property (p_channel_read) else $error("channel select mismatch");

  property p_words_frozen;  // R9
    config_valid |=> $stable(cfg_word[0]) && $stable(cfg_word[3]) && config_valid;
  endproperty
  a_words_frozen: assert property (p_words_frozen) else $error("latched word changed");

  property p_valid_soon;  // R9
    $rose(hresetn) |-> ##[1:5] config_valid;
  endproperty
  a_valid_soon: assert property (@(posedge hclk) p_valid_soon) else $error("words never latched");

endmodule // device_config_words

// [pkg/device_config_params.svh]
`ifndef DEVICE_CONFIG_PARAMS_SVH
`define DEVICE_CONFIG_PARAMS_SVH

// word byte addresses on the register bus
`define CFG_WORD3_ADDR   32'hbfc02ff0
`define CFG_WORD2_ADDR   32'hbfc02ff4
`define CFG_WORD1_ADDR   32'hbfc02ff8
`define CFG_WORD0_ADDR   32'hbfc02ffc
`define IDENT_WORD_ADDR  32'hbf80f220
`define STATUS_WORD_ADDR 32'hbf80f224

// protection word field positions
`define CODE_PROTECT_BIT 28
`define BOOT_WP_BIT      24
`define PAGE_WP_MSB      19
`define PAGE_WP_LSB      12
`define DBG_SEL_BIT      3
`define DBG_EN_MSB       1
`define DBG_EN_LSB       0

// debugger enable codes
`define DBG_EN_ON        2'h2
`define DBG_EN_OFF       2'h3

// user id and identification fields
`define USER_ID_MSB      15
`define USER_ID_LSB      0
`define REV_MSB          31
`define REV_LSB          28
`define PART_MSB         19
`define PART_LSB         12
`define MAKER_MSB        11
`define MAKER_LSB        0

// status word field positions
`define STAT_VALID_BIT   0
`define STAT_CP_BIT      1
`define STAT_DBG_BIT     2
`define STAT_BOOT_BIT    3
`define STAT_PAGES_LSB   4
`define STAT_PAGES_MSB   11

// reset values: erased nonvolatile cells read as ones
`define CFG_ERASED       32'hffffffff
`define RDATA_RESET      32'h00000000

// sync stages before a word may be captured
`define LATCH_FILL       2'h3

`endif

// [pkg/device_config_pkg.sv]
package device_config_pkg;

  // registered state of the configuration word block
  typedef struct packed {
    logic [31:0] rdata;       // read data of the current data phase
    logic        prog_grant;  // programmer access granted
    logic        prog_deny;   // programmer access refused
    logic        boot_grant;  // boot flash write granted
    logic        boot_deny;   // boot flash write refused
    logic        page_grant;  // program page write granted
    logic        page_deny;   // program page write refused
    logic        dbg_en;      // background debugger enabled
    logic        dbg_sel;     // debug pin pair select
  } cfg_state_t;

endpackage

// [test/device_config_words_tb.sv]
`timescale 1ns/1ps
`include "device_config_params.svh"

// self-checking bench for the configuration word block
module device_config_words_tb;
  localparam logic [3:0]  REV      = 4'h3;    // arbitrary value
  localparam logic [7:0]  PART_ID  = 8'hc3;   // arbitrary value
  localparam logic [11:0] MAKER_ID = 12'h7b1; // arbitrary value, bit 0 one

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;  // bus control
  logic [31:0] haddr, hwdata, hrdata;                          // bus address and data
  logic [1:0]  htrans;                                         // transfer type
  logic [2:0]  hsize;                                          // transfer size
  logic [31:0] nv0, nv1, nv2, nv3;                             // programmed words
  logic        prog_req, boot_req, page_req;                   // request lines
  logic [7:0]  page_idx, np_m;                                 // page number, locked count
  logic        pg, pd, bg, bd, wg, wd, dbg_en, dbg_sel, cfg_valid; // answers
  logic [31:0] seed, w, rd, a, x, m;                           // scratch
  logic [31:0] e [4];                                          // expected words
  logic [6:0]  exp_q;                                          // expected answers
  logic        v_q;                                            // valid one edge ago
  int          n_errors, cmp_count, cyc, i, j, k;              // counters

  device_config_words #(.REVISION(REV), .PART(PART_ID), .MAKER(MAKER_ID)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .nv_word0(nv0), .nv_word1(nv1), .nv_word2(nv2), .nv_word3(nv3),
    .prog_access_req(prog_req), .prog_access_grant(pg), .prog_access_deny(pd),
    .boot_write_req(boot_req), .boot_write_grant(bg), .boot_write_deny(bd),
    .page_write_req(page_req), .page_write_index(page_idx),
    .page_write_grant(wg), .page_write_deny(wd), .debug_enable(dbg_en),
    .debug_channel_select(dbg_sel), .config_valid(cfg_valid));

  flash_programmer_model u_prog (.nv_word0(nv0), .nv_word1(nv1), .nv_word2(nv2),
    .nv_word3(nv3), .prog_access_req(prog_req));

  // 200 mhz clock
  always #2.5 hclk = ~hclk;

  // xorshift source, fixed seed
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // automatic: called from the answer model and the main flow at one edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wrap_up();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // single word transfer, waits on ready in both phases
  task bus(input logic wr, input logic [31:0] ad, input logic [31:0] wv, output logic [31:0] d);
    hsel <= 1'b1; haddr <= ad; htrans <= 2'h2; hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wv;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  // answer model: outputs seen now answer the inputs of the last edge
  always @(posedge hclk) begin
    if (!hresetn) begin
      exp_q = 7'h00;
      v_q = 1'b0;
    end else begin
      chk({25'h0, pg, pd, bg, bd, wg, wd, dbg_en}, {25'h0, exp_q});
      if (v_q) chk({31'h0, dbg_sel}, {31'h0, e[0][3]});
      v_q = (cfg_valid === 1'b1);
      np_m = ~e[0][19:12];
      exp_q = {prog_req & v_q & e[0][28], prog_req & !(v_q & e[0][28]),
               boot_req & v_q & e[0][24], boot_req & !(v_q & e[0][24]),
               page_req & v_q & (page_idx >= np_m), page_req & !(v_q & (page_idx >= np_m)),
               v_q & e[0][28] & (e[0][1:0] == 2'b10)};
    end
  end

  // hang guard, far above the expected run length
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; boot_req = 0; page_req = 0; page_idx = 0;
    seed = 32'h97a6f504; n_errors = 0; cmp_count = 0; cyc = 0;
    e = '{default: 32'hffffffff};
    // each pass reprograms, resets and recaptures the words
    for (i = 0; i < 8; i++) begin
      @(posedge hclk);
      hresetn <= 1'b0;
      // expected words change only once reset is seen, never under a live check
      @(posedge hclk);
      w = xs();
      w[28] = i[2];
      w[24] = i[0] ^ i[1];
      w[1:0] = i[1:0];
      if (i == 0) w[19:12] = 8'hff;
      if (i == 1) w[19:12] = 8'h00;
      if (i == 2) w[19:12] = 8'hfe;
      e[1] = xs(); e[2] = xs(); e[3] = xs();
      // tb model of the kept reserved bits
      e[0] = (w | 32'h0ef00ff4) & 32'h1fffffff;
      u_prog.program_words(w, e[1], e[2], e[3]);
      repeat (7) @(posedge hclk);
      hresetn <= 1'b1;
      // requests before capture must all be refused
      boot_req <= 1'b1; page_req <= 1'b1; u_prog.drive(1'b1);
      @(posedge hclk);
      boot_req <= 1'b0; page_req <= 1'b0; u_prog.drive(1'b0);
      k = 0;
      while (cfg_valid !== 1'b1 && k < 16) begin
        @(posedge hclk);
        k++;
      end
      chk({31'h0, cfg_valid}, 32'h00000001);
      // words, identity, write attempt, readback, unmapped place, status
      for (j = 0; j < 9; j++) begin
        a = j < 4 ? `CFG_WORD3_ADDR + 32'(4 * j) : j == 4 ? `IDENT_WORD_ADDR :
            j == 7 ? 32'hbf80f230 : j == 8 ? `STATUS_WORD_ADDR : `CFG_WORD0_ADDR;
        bus(j == 5, a, ~e[0], rd);
        // a write is not a read: read data keeps the identification word
        x = j < 4 ? e[3 - j] : (j == 4 || j == 5) ? {REV, 8'h00, PART_ID, MAKER_ID} :
            j == 7 ? 32'h0 :
            j == 8 ? {20'h0, ~e[0][19:12], ~e[0][24], e[0][28] & (e[0][1:0] == 2'b10),
                      ~e[0][28], 1'b1} : e[0];
        m = (j == 4 || j == 5) ? 32'hf00fffff : 32'hffffffff;
        chk(rd & m, x & m);
        chk({31'h0, hresp}, 32'h00000000);
      end
      // random back-to-back requests, pages around the locked boundary
      for (j = 0; j < 40; j++) begin
        w = xs();
        boot_req <= w[0]; page_req <= w[1]; u_prog.drive(w[2]);
        page_idx <= w[4:3] == 2'h0 ? ~e[0][19:12] - 8'h01 :
                    w[4:3] == 2'h1 ? ~e[0][19:12] : w[15:8];
        @(posedge hclk);
      end
      boot_req <= 1'b0; page_req <= 1'b0; u_prog.drive(1'b0);
    end
    repeat (2) @(posedge hclk);
    wrap_up();
  end
endmodule // device_config_words_tb

// [test/flash_programmer_model.sv]
`timescale 1ns/1ps

// behavioural stand-in for the external flash programmer
module flash_programmer_model (
  output logic [31:0] nv_word0,
  output logic [31:0] nv_word1,
  output logic [31:0] nv_word2,
  output logic [31:0] nv_word3,
  output logic        prog_access_req
);
  // erased cells read as ones until the first programming pass
  initial begin
    {nv_word0, nv_word1, nv_word2, nv_word3} = {4{32'hffffffff}};
    prog_access_req = 1'b0;
  end

  // words are only reprogrammed while the device sits in reset
  // reserved protection bits kept at one, bits 31 to 29 cleared
  task program_words(input logic [31:0] w0, input logic [31:0] w1,
                     input logic [31:0] w2, input logic [31:0] w3);
    nv_word0 <= (w0 | 32'h0ef00ff4) & 32'h1fffffff;
    nv_word1 <= w1;
    nv_word2 <= w2;
    nv_word3 <= w3;
  endtask

  // access attempt level for the coming edge
  task drive(input logic v);
    prog_access_req <= v;
  endtask
endmodule // flash_programmer_model
